// file: inc/hsreg_pkg.sv
// Constants and types shared by the hot-plug register bank.
// Assumes a 10 MHz system clock that oversamples the serial bus.
package hsreg_pkg;
    // Register pointers on the serial bus
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ALERT  = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_FAULT  = 8'h03;
    localparam logic [7:0] REG_SENSE  = 8'h04;
    localparam logic [7:0] REG_SOURCE = 8'h05;
    localparam logic [7:0] REG_AUX    = 8'h06;

    // Alert enable layout; bit 7 is reserved and reads zero
    localparam int ALERT_GPIO_OUT = 6;
    localparam logic [7:0] ALERT_WMASK = 8'h7F;
    // Fault layout; bits 7:6 reserved
    localparam int FLT_SHORT = 5;
    localparam int FLT_EN    = 4;
    localparam int FLT_PBAD  = 3;
    localparam int FLT_OC    = 2;
    localparam int FLT_UV    = 1;
    localparam int FLT_OV    = 0;
    localparam int FLT_W     = 6;
    // Control fields kept here: overcurrent retry and gpio mode
    localparam int CTRL_OC_RETRY = 2;
    localparam int CTRL_GPIO_LO  = 6;
    localparam logic [1:0] GPIO_PGOOD  = 2'b00;
    localparam logic [1:0] GPIO_PBAD   = 2'b10;
    localparam logic [1:0] GPIO_OUTPUT = 2'b01;
    localparam logic [1:0] GPIO_INPUT  = 2'b11;

    // Synchronised pin vector positions
    localparam int PIN_GPIO  = 0;
    localparam int PIN_EN_N  = 1;
    localparam int PIN_PGFB  = 2;
    localparam int PIN_UV    = 3;
    localparam int PIN_OV    = 4;
    localparam int PIN_VDDOV = 5;
    localparam int PIN_SHORT = 6;
    localparam int PIN_OCOOL = 7;
    localparam int PIN_SWON  = 8;
    localparam int PIN_SCL   = 9;
    localparam int PIN_SDA   = 10;
    localparam int PIN_W     = 11;

    // Converter scaling, for software reference
    localparam int SENSE_LSB_NV   = 151000;
    localparam int SENSE_FS_UV    = 38450;
    localparam int SOURCE_LSB_UV  = 60500;
    localparam int SOURCE_FS_MV   = 15440;
    localparam int AUX_LSB_UV     = 4820;
    localparam int AUX_FS_MV      = 1230;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT      = 4'h7;

    typedef enum logic [8:0] {
        S_IDLE  = 9'h001,
        S_ADDR  = 9'h002,
        S_AACK  = 9'h004,
        S_PTR   = 9'h008,
        S_PACK  = 9'h010,
        S_WDATA = 9'h020,
        S_WACK  = 9'h040,
        S_RDATA = 9'h080,
        S_RACK  = 9'h100
    } hsreg_state_t;
endpackage

// file: logic/hsreg_bank.sv
// Register bank of a hot-plug power controller behind a two-wire serial
// slave. Assumes analog comparators, converter and gate control outside;
// their levels arrive asynchronously, converter words on the local clock.
//
// Contract
// - alert bit 6 drives gpio output, resets 0
// - alert bit 5 enables switch-short alert
// - alert bit 4 enables enable-change alert
// - alert bit 3 enables power-bad alert
// - alert bit 2 enables overcurrent alert
// - alert bits 1,0 enable undervoltage, overvoltage
// - status bit 7 shows switch on
// - status bit 6 shows gpio level
// - status bit 5 shows sense above 1mV, switch off
// - status bit 4 shows enable pin inverted
// - status bit 3 shows feedback low
// - status bit 2 shows overcurrent cool-down
// - status bit 1 shows undervoltage input low
// - status bit 0 shows any overvoltage high
// - fault bit 5 records switch short
// - fault bit 4 records enable change
// - fault bit 3 records feedback went low
// - fault bit 2 records overcurrent fault
// - fault bits 1,0 record undervoltage, overvoltage
// - sense register holds 8-bit converter result
// - source register holds 8-bit converter result
// - aux register holds 8-bit converter result
// - control bit selects overcurrent retry or latch
`timescale 1ns/1ps
`default_nettype none
module hsreg_bank
    import hsreg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR   = 7'h2A,  // arbitrary default
    parameter logic [7:0] CTRL_RESET = 8'h0B
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Serial bus, open drain
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // General-purpose pin
    input  wire logic       gpio_in,
    output logic            gpio_out,
    output logic            gpio_oe,
    // Asynchronous condition levels
    input  wire logic       enable_n_pin,
    input  wire logic       power_good_feedback,
    input  wire logic       undervoltage_input,
    input  wire logic       overvoltage_input,
    input  wire logic       supply_ov_detect,
    input  wire logic       sense_over_1mv,
    input  wire logic       overcurrent_cooldown,
    input  wire logic       pass_switch_on,
    // Converter results, local clock
    input  wire logic       adc_valid,
    input  wire logic [7:0] sense_result,
    input  wire logic [7:0] source_result,
    input  wire logic [7:0] aux_result,
    // Outputs to the controller
    output logic            overcurrent_auto_retry,
    output logic            alert
);
    typedef struct packed {
        logic [PIN_W-1:0] pin_s1;
        logic [PIN_W-1:0] pin_s2;
        logic [PIN_W-1:0] pin_d;
        hsreg_state_t     state;
        logic [3:0]       bitcnt;
        logic [7:0]       shreg;
        logic [7:0]       ptr;
        logic             rw;
        logic             mack;
        logic             sda_oe;
        logic [7:0]       ctrl;
        logic [7:0]       alert_en;
        logic [FLT_W-1:0] fault;
        logic [7:0]       sense;
        logic [7:0]       source;
        logic [7:0]       aux;
        logic             gpio_o;
        logic             gpio_e;
        logic             alert;
    } hsreg_bank_t;

    localparam hsreg_bank_t ST_RESET = '{
        state: S_IDLE, ctrl: CTRL_RESET, default: '0};

    hsreg_bank_t q;
    hsreg_bank_t next_q;

    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] cur;
    logic [7:0]       live_status;
    logic [FLT_W-1:0] fault_set;
    logic             scl_rise;
    logic             scl_fall;
    logic             bus_start;
    logic             bus_stop;
    logic             wr_fault;
    logic [7:0]       ptr_inc;

    assign pins = {sda_in, scl_in, pass_switch_on, overcurrent_cooldown,
                   sense_over_1mv, supply_ov_detect, overvoltage_input,
                   undervoltage_input, power_good_feedback, enable_n_pin,
                   gpio_in};
    // The logic looks at the second stage and at its one-cycle delayed copy pin_d
    assign cur = q.pin_s2;

    assign live_status = {
        cur[PIN_SWON],
        cur[PIN_GPIO],
        cur[PIN_SHORT] & ~cur[PIN_SWON],
        ~cur[PIN_EN_N],
        ~cur[PIN_PGFB],
        cur[PIN_OCOOL],
        ~cur[PIN_UV],
        cur[PIN_OV] | cur[PIN_VDDOV]};

    always_comb begin
        fault_set = '0;
        fault_set[FLT_SHORT] = live_status[5]
            & ~(q.pin_d[PIN_SHORT] & ~q.pin_d[PIN_SWON]);
        fault_set[FLT_EN]    = cur[PIN_EN_N] ^ q.pin_d[PIN_EN_N];
        fault_set[FLT_PBAD]  = ~cur[PIN_PGFB] & q.pin_d[PIN_PGFB];
        fault_set[FLT_OC]    = cur[PIN_OCOOL] & ~q.pin_d[PIN_OCOOL];
        fault_set[FLT_UV]    = ~cur[PIN_UV] & q.pin_d[PIN_UV];
        fault_set[FLT_OV]    = live_status[0]
            & ~(q.pin_d[PIN_OV] | q.pin_d[PIN_VDDOV]);
    end

    assign scl_rise  = cur[PIN_SCL] & ~q.pin_d[PIN_SCL];
    assign scl_fall  = ~cur[PIN_SCL] & q.pin_d[PIN_SCL];
    assign bus_start = cur[PIN_SCL] & q.pin_d[PIN_SCL]
                     & ~cur[PIN_SDA] & q.pin_d[PIN_SDA];
    assign bus_stop  = cur[PIN_SCL] & q.pin_d[PIN_SCL]
                     & cur[PIN_SDA] & ~q.pin_d[PIN_SDA];
    assign ptr_inc   = q.ptr + 8'h01;

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == REG_CTRL) begin
            d = q.ctrl;
        end else if (a == REG_ALERT) begin
            d = q.alert_en & ALERT_WMASK;
        end else if (a == REG_STATUS) begin
            d = live_status;
        end else if (a == REG_FAULT) begin
            d = {{(8-FLT_W){1'b0}}, q.fault};
        end else if (a == REG_SENSE) begin
            d = q.sense;
        end else if (a == REG_SOURCE) begin
            d = q.source;
        end else if (a == REG_AUX) begin
            d = q.aux;
        end
        return d;
    endfunction

    always_comb begin
        next_q = q;
        wr_fault = 1'b0;
        next_q.pin_s1 = pins;
        next_q.pin_s2 = q.pin_s1;
        next_q.pin_d  = q.pin_s2;

        case (q.state)
            S_ADDR, S_PTR, S_WDATA: begin
                if (scl_rise) begin
                    next_q.shreg  = {q.shreg[6:0], cur[PIN_SDA]};
                    next_q.bitcnt = q.bitcnt + 4'h1;
                end else if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
                    next_q.bitcnt = '0;
                    next_q.sda_oe = 1'b1;
                    if (q.state == S_ADDR) begin
                        next_q.rw    = q.shreg[0];
                        next_q.state = S_AACK;
                        if (q.shreg[7:1] != DEV_ADDR) begin
                            next_q.sda_oe = 1'b0;
                            next_q.state  = S_IDLE;
                        end
                    end else if (q.state == S_PTR) begin
                        next_q.ptr   = q.shreg;
                        next_q.state = S_PACK;
                    end else begin
                        next_q.state = S_WACK;
                        if (q.ptr == REG_CTRL) begin
                            next_q.ctrl = q.shreg;
                        end else if (q.ptr == REG_ALERT) begin
                            next_q.alert_en = q.shreg & ALERT_WMASK;
                        end else if (q.ptr == REG_FAULT) begin
                            wr_fault = 1'b1;
                            next_q.fault = q.fault & q.shreg[FLT_W-1:0];
                        end else if (q.ptr == REG_SENSE) begin
                            next_q.sense = q.shreg;
                        end else if (q.ptr == REG_SOURCE) begin
                            next_q.source = q.shreg;
                        end else if (q.ptr == REG_AUX) begin
                            next_q.aux = q.shreg;
                        end
                    end
                end
            end
            S_AACK, S_PACK, S_WACK: begin
                if (scl_fall) begin
                    next_q.sda_oe = 1'b0;
                    next_q.bitcnt = '0;
                    if (q.state == S_AACK && q.rw) begin
                        next_q.shreg  = read_reg(q.ptr);
                        next_q.sda_oe = ~next_q.shreg[7];
                        next_q.state  = S_RDATA;
                    end else if (q.state == S_AACK) begin
                        next_q.state = S_PTR;
                    end else begin
                        // Auto-increment lets a burst fill neighbours
                        if (q.state == S_WACK) begin
                            next_q.ptr = ptr_inc;
                        end
                        next_q.state = S_WDATA;
                    end
                end
            end
            S_RDATA: begin
                if (scl_fall) begin
                    if (q.bitcnt == LAST_BIT) begin
                        next_q.sda_oe = 1'b0;
                        next_q.state  = S_RACK;
                    end else begin
                        next_q.shreg  = {q.shreg[6:0], 1'b0};
                        next_q.sda_oe = ~q.shreg[6];
                        next_q.bitcnt = q.bitcnt + 4'h1;
                    end
                end
            end
            S_RACK: begin
                if (scl_rise) begin
                    next_q.mack = ~cur[PIN_SDA];
                end else if (scl_fall) begin
                    next_q.bitcnt = '0;
                    if (q.mack) begin
                        next_q.ptr    = ptr_inc;
                        next_q.shreg  = read_reg(ptr_inc);
                        next_q.sda_oe = ~next_q.shreg[7];
                        next_q.state  = S_RDATA;
                    end else begin
                        next_q.state = S_IDLE;
                    end
                end
            end
            default: begin
                next_q.state = S_IDLE;
            end
        endcase

        // Start and stop override any byte in progress
        if (bus_start) begin
            next_q.state  = S_ADDR;
            next_q.bitcnt = '0;
            next_q.sda_oe = 1'b0;
        end else if (bus_stop) begin
            next_q.state  = S_IDLE;
            next_q.sda_oe = 1'b0;
        end

        // a new event beats a same-cycle clear
        next_q.fault = next_q.fault | fault_set;

        // converter update wins over host write
        if (adc_valid) begin
            next_q.sense  = sense_result;
            next_q.source = source_result;
            next_q.aux    = aux_result;
        end

        next_q.alert = |(q.fault & q.alert_en[FLT_W-1:0]);

        next_q.gpio_e = 1'b1;
        case (q.ctrl[CTRL_GPIO_LO +: 2])
            GPIO_PGOOD:  next_q.gpio_o = ~live_status[3];
            GPIO_PBAD:   next_q.gpio_o = live_status[3];
            GPIO_OUTPUT: next_q.gpio_o = q.alert_en[ALERT_GPIO_OUT];
            default: begin
                next_q.gpio_o = 1'b0;
                next_q.gpio_e = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= ST_RESET;
        end else begin
            q <= next_q;
        end
    end

    // Open drain: the line is only ever pulled low
    assign sda_out  = 1'b0;
    assign sda_oe   = q.sda_oe;
    assign gpio_out = q.gpio_o;
    assign gpio_oe  = q.gpio_e;
    assign overcurrent_auto_retry = q.ctrl[CTRL_OC_RETRY];
    assign alert = q.alert;

    property p_gpio_drive;
        @(posedge clk) disable iff (!resetn)
        q.ctrl[CTRL_GPIO_LO +: 2] == GPIO_OUTPUT
            |=> gpio_oe && gpio_out == $past(q.alert_en[ALERT_GPIO_OUT]);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive)
        else $error("gpio output does not follow alert bit 6");

    property p_alert_on;
        @(posedge clk) disable iff (!resetn)
        |(q.fault & q.alert_en[FLT_W-1:0]) |=> alert;
    endproperty
    a_alert_on: assert property (p_alert_on)
        else $error("alert missing for enabled fault");

    property p_alert_masked;
        @(posedge clk) disable iff (!resetn)
        (q.alert_en[FLT_W-1:0] == '0) ##1 (q.alert_en[FLT_W-1:0] == '0)
            |-> !alert;
    endproperty
    a_alert_masked: assert property (p_alert_masked)
        else $error("alert raised with all enables clear");

    property p_switch_status;
        @(posedge clk) disable iff (!resetn)
        pass_switch_on [*4] |-> live_status[7] && !live_status[5];
    endproperty
    a_switch_status: assert property (p_switch_status)
        else $error("switch status or short flag wrong while on");

    property p_enable_status;
        @(posedge clk) disable iff (!resetn)
        !enable_n_pin [*4] |-> live_status[4];
    endproperty
    a_enable_status: assert property (p_enable_status)
        else $error("enable status not set with pin low");

    property p_en_change;
        @(posedge clk) disable iff (!resetn)
        $changed(q.pin_s2[PIN_EN_N]) |=> q.fault[FLT_EN];
    endproperty
    a_en_change: assert property (p_en_change)
        else $error("enable change not recorded");

    property p_fb_low;
        @(posedge clk) disable iff (!resetn)
        $fell(q.pin_s2[PIN_PGFB]) |=> q.fault[FLT_PBAD] [*2];
    endproperty
    a_fb_low: assert property (p_fb_low)
        else $error("power bad not recorded or lost");

    property p_fault_sticky;
        @(posedge clk) disable iff (!resetn)
        q.fault[FLT_OC] && !wr_fault |=> q.fault[FLT_OC];
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault bit dropped without host write");

    property p_adc_load;
        @(posedge clk) disable iff (!resetn)
        adc_valid |=> q.sense == $past(sense_result)
            && q.aux == $past(aux_result);
    endproperty
    a_adc_load: assert property (p_adc_load)
        else $error("converter result not captured");

    c_write: cover property (@(posedge clk) disable iff (!resetn)
        q.state == S_WACK);
    c_read: cover property (@(posedge clk) disable iff (!resetn)
        q.state == S_RACK ##1 q.state == S_RDATA);
    c_alert: cover property (@(posedge clk) disable iff (!resetn)
        $rose(alert));
endmodule
`default_nettype wire

// file: tb/hsreg_host_model.sv
// Behavioural two-wire bus host that drives the register bank.
// Assumes a 10 MHz clock; one bus bit spans 8 clocks (800 ns).
`timescale 1ns/1ps
`default_nettype none
module hsreg_host_model (
    // Clock
    input  wire logic       clk,
    // Bus lines; the device only pulls data low
    input  wire logic       dev_pull,
    output logic            scl,
    output wire logic       sda,
    // Read results
    output logic [7:0]      got,
    output logic            got_vld
);
    logic pull;

    // Pull-up: a released line reads high
    assign sda = ~(pull | dev_pull);

    initial begin
        scl = 1'b1;
        pull = 1'b0;
        got = 8'h00;
        got_vld = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Data moves 1 clock after scl falls, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        w(1);
        pull = ~b;
        w(3);
        scl = 1'b1;
        w(2);
        r = sda;
        w(2);
        scl = 1'b0;
    endtask

    task automatic start();
        w(1);
        pull = 1'b0;
        w(3);
        scl = 1'b1;
        w(2);
        pull = 1'b1;
        w(2);
        scl = 1'b0;
    endtask

    // Clock stays high between frames
    task automatic stop();
        w(1);
        pull = 1'b1;
        w(3);
        scl = 1'b1;
        w(2);
        pull = 1'b0;
        w(4);
    endtask

    // Sending all ones releases the line, so reads end with a nack
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                           output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(1'b1, nak);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                      output logic nak);
        logic [7:0] q;
        logic       n0, n1, n2;
        start();
        byte_io({a, 1'b0}, q, n0);
        byte_io(p, q, n1);
        byte_io(d, q, n2);
        stop();
        nak = n0 | n1 | n2;
    endtask

    // Reads cnt bytes from pointer p; every byte but the last is acked
    task automatic rd(input logic [6:0] a, input logic [7:0] p,
                      input int cnt);
        logic [7:0] q;
        logic       n;
        start();
        byte_io({a, 1'b0}, q, n);
        byte_io(p, q, n);
        start();
        byte_io({a, 1'b1}, q, n);
        for (int k = 0; k < cnt; k++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_io(1'b1, q[i]);
            end
            bit_io(k == cnt - 1, n);
            // Clock is low here, so the pulse only stretches the low phase
            got = q;
            got_vld = 1'b1;
            w(1);
            got_vld = 1'b0;
        end
        stop();
    endtask
endmodule
`default_nettype wire

// file: tb/test_hotswap_alert_status_fault_regs.sv
// Self-checking bench for the hot-plug register bank.
// Assumes the package and the bus host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_hotswap_alert_status_fault_regs
    import hsreg_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h2A;  // arbitrary bus address

    logic       clk, resetn, gpio_drv, en_n, pgfb, uv, ov, sov, sns;
    logic       cool, sw, adc_valid, nak;
    logic [7:0] sns_r, src_r, aux_r, got;
    logic       got_vld, scl;
    wire logic  sda, sda_oe, sda_out, gpio_out, gpio_oe, alert, retry;
    wire logic  gpio_w;
    logic [7:0] exp_q[$];
    int         bad_count, samples_checked, cyc, seed;

    assign gpio_w = gpio_oe ? gpio_out : gpio_drv;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    hsreg_bank #(.DEV_ADDR(ADDR)) dut (
        .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .gpio_in(gpio_w),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .enable_n_pin(en_n),
        .power_good_feedback(pgfb), .undervoltage_input(uv),
        .overvoltage_input(ov), .supply_ov_detect(sov),
        .sense_over_1mv(sns), .overcurrent_cooldown(cool),
        .pass_switch_on(sw), .adc_valid(adc_valid),
        .sense_result(sns_r), .source_result(src_r), .aux_result(aux_r),
        .overcurrent_auto_retry(retry), .alert(alert));

    hsreg_host_model host (
        .clk(clk), .dev_pull(sda_oe & ~sda_out), .scl(scl), .sda(sda),
        .got(got), .got_vld(got_vld));

    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] v, e);
        samples_checked++;
        if (v !== e) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, v, e);
        end
    endtask

    // Each read result is matched against the oldest note
    always @(posedge clk) begin
        if (got_vld === 1'b1) begin
            chk(got, exp_q.pop_front());
        end
    end

    // Guards against a bus that never finishes
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic rd_exp(input logic [7:0] p, e);
        exp_q.push_back(e);
        host.rd(ADDR, p, 1);
    endtask

    task automatic wr(input logic [7:0] p, d);
        logic n;
        host.wr(ADDR, p, d, n);
        chk({7'h00, n}, 8'h00);
    endtask

    // Expected status from the pin levels, gpio in input mode
    function automatic logic [7:0] stat();
        return {sw, gpio_drv, sns & ~sw, ~en_n, ~pgfb, cool, ~uv, ov | sov};
    endfunction

    task automatic set_cond(input int i, input logic v);
        case (i)
            FLT_SHORT: sns = v;
            FLT_EN:    en_n = v;
            FLT_PBAD:  pgfb = ~v;
            FLT_OC:    cool = v;
            FLT_UV:    uv = ~v;
            default: begin
                ov = v & seed[0];
                sov = v & ~seed[0];
            end
        endcase
        repeat (6) @(negedge clk);
    endtask

    initial begin
        seed = 48;
        {resetn, gpio_drv, en_n, ov, sov, sns, cool, sw, adc_valid} = 9'h000;
        {pgfb, uv} = 2'b11;
        {sns_r, src_r, aux_r} = 24'h000000;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk({7'h00, retry}, 8'h00);
        // Default gpio mode drives the inverse of power bad
        chk({6'h00, gpio_oe, gpio_out}, 8'h03);
        rd_exp(REG_ALERT, 8'h00);
        rd_exp(REG_SENSE, 8'h00);
        wr(REG_ALERT, 8'hFF);
        rd_exp(REG_ALERT, 8'h7F);
        // Output mode with auto-retry: gpio follows alert bit 6
        wr(REG_CTRL, 8'h4F);
        chk({7'h00, retry}, 8'h01);
        chk({6'h00, gpio_oe, gpio_out}, 8'h03);
        wr(REG_ALERT, 8'h00);
        chk({6'h00, gpio_oe, gpio_out}, 8'h02);
        // Power-bad mode copies status bit 3 to the pin
        wr(REG_CTRL, 8'h8B);
        chk({6'h00, gpio_oe, gpio_out}, 8'h02);
        wr(REG_CTRL, 8'hCB);
        for (int i = 0; i < FLT_W; i++) begin
            gpio_drv = 1'($random(seed));
            sw = (i == FLT_SHORT) ? 1'b0 : 1'($random(seed));
            wr(REG_ALERT, 8'h01 << i);
            wr(REG_FAULT, 8'h00);
            chk({7'h00, alert}, 8'h00);
            set_cond(i, 1'b1);
            rd_exp(REG_STATUS, stat());
            rd_exp(REG_FAULT, 8'h01 << i);
            chk({7'h00, alert}, 8'h01);
            set_cond(i, 1'b0);
            rd_exp(REG_FAULT, 8'h01 << i);
            wr(REG_FAULT, 8'h00);
            chk({7'h00, alert}, 8'h00);
            rd_exp(REG_STATUS, stat());
        end
        sns_r = 8'($random(seed));
        src_r = 8'($random(seed));
        aux_r = 8'($random(seed));
        adc_valid = 1'b1;
        @(negedge clk);
        adc_valid = 1'b0;
        rd_exp(REG_SENSE, sns_r);
        rd_exp(REG_SOURCE, src_r);
        rd_exp(REG_AUX, aux_r);
        wr(REG_AUX, 8'hA5);
        rd_exp(REG_AUX, 8'hA5);
        // A host ack walks the pointer on to the next result
        exp_q.push_back(src_r);
        exp_q.push_back(8'hA5);
        host.rd(ADDR, REG_SOURCE, 2);
        // A foreign address must be ignored and left unacknowledged
        host.wr(ADDR ^ 7'h01, REG_ALERT, 8'h3C, nak);
        chk({7'h00, nak}, 8'h01);
        rd_exp(REG_ALERT, 8'h20);
        rd_exp(8'h07, 8'h00);
        // Reset in mid-run must bring enables and gpio mode back
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk({6'h00, gpio_oe, gpio_out}, 8'h03);
        rd_exp(REG_ALERT, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
